// >>> bench/cbaz_counter_bench.sv
// self-checking bench for the auto-zero counter
`timescale 1ns/1ps
`default_nettype none
module cbaz_counter_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic sch_b = 1'b0;
    logic signed [2:0] off = 3'sh0;
    logic signed [2:0] vin = 3'sh0;
    wire logic comp, ph1, ph2, neg, inv, ok, ovr, swn;
    wire logic [cbaz_pkg::READ_W-1:0] rd;
    int n_fail = 0;
    int checks = 0;
    // 100 MHz
    always #5 sys_clk = ~sys_clk;
    // short phases keep the run brief; expectations scale with them
    cbaz_counter #(.PHASE_CLKS(40), .SETTLE_CLKS(8)) dut (
        .SYS_CLK(sys_clk), .RSTN(rstn), .COMP_IN(comp), .MOD_OUT(),
        .SWITCH_POS(), .SWITCH_NEG(swn), .FIRST_PHASE_INDICATOR(ph1),
        .SECOND_PHASE_INDICATOR(ph2), .READING(rd), .READING_NEG(neg),
        .OVERRANGE_FLAG(ovr), .INVALID_FLAG(inv), .READING_VALID(ok));
    cbaz_loop_model u_loop (.clk(sys_clk), .rst_n(rstn), .ph1(ph1),
        .ph2(ph2), .scheme_b(sch_b), .offset(off), .vin(vin), .comp(comp));
    task automatic test_done;
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input int exp,
        input logic [15:0] got);
        checks++;
        if (got !== exp[15:0]) begin
            n_fail++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick
    // bounded wait for the end of a measurement cycle
    task automatic wait_end;
        int i;
        int j;
        for (i = 0; i < 300 && ph2 !== 1'b1; i++) tick();
        for (j = 0; j < 300 && ph2 !== 1'b0; j++) tick();
        if (i == 300 || j == 300) begin
            check("cycle end", 1, 0);
            test_done();
        end
    endtask : wait_end
    // one full cycle with fixed input settings, then let the result land
    task automatic measure(input logic b, input logic signed [2:0] o,
        input logic signed [2:0] v);
        wait_end();
        {sch_b, off, vin} = {b, o, v};
        wait_end();
        repeat (3) tick();
    endtask : measure
    // raw count is +10 per step of density; display rounds quarter counts
    // overrange at 2000 of 5000 periods, scaled to the 40 clock phase
    task automatic expect_result(input int acc, input logic bad);
        int mag;
        logic over;
        mag = acc < 0 ? -acc : acc;
        over = mag >= cbaz_pkg::OVERRANGE * cbaz_pkg::PRESCALE * 40 /
            cbaz_pkg::PHASE_LEN;
        check("reading", over ? 1999 : (mag + 2) >> 2, rd);
        check("sign", acc < 0, neg);
        check("valid", 1, ok);
        check("invalid", bad, inv);
        check("overrange", over, ovr);
    endtask : expect_result
    task automatic t_zero;
        measure(1'b0, 3'sh0, 3'sh0);
        expect_result(0, 1'b0);
    endtask : t_zero
    task automatic t_offset;
        measure(1'b0, 3'sh1, 3'sh0);
        expect_result(0, 1'b0);
    endtask : t_offset
    task automatic t_scheme_a;
        measure(1'b0, 3'sh0, 3'sh1);
        expect_result(10, 1'b0);
        measure(1'b0, 3'sh7, 3'sh2);
        expect_result(20, 1'b0);
    endtask : t_scheme_a
    task automatic t_scheme_b;
        measure(1'b1, 3'sh0, 3'sh1);
        expect_result(20, 1'b0);
    endtask : t_scheme_b
    task automatic t_negative;
        measure(1'b0, 3'sh0, 3'sh7);
        expect_result(-10, 1'b0);
    endtask : t_negative
    task automatic t_saturate;
        measure(1'b1, 3'sh0, 3'sh2);
        expect_result(40, 1'b1);
        measure(1'b0, 3'sh0, 3'sh1);
        expect_result(10, 1'b0);
    endtask : t_saturate
    task automatic t_reset;
        repeat (30) tick();
        rstn = 1'b0;
        tick();
        check("switch_neg in reset", 1, swn);
        check("reading in reset", 0, rd);
        rstn = 1'b1;
        measure(1'b0, 3'sh0, 3'sh1);
        expect_result(10, 1'b0);
    endtask : t_reset
    initial begin
        repeat (16) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        t_zero();
        t_offset();
        t_scheme_a();
        t_scheme_b();
        t_negative();
        t_saturate();
        t_reset();
        test_done();
    end
endmodule : cbaz_counter_bench
`default_nettype wire

// >>> bench/cbaz_loop_model.sv
// model of the outside input switches and the analog loop
`timescale 1ns/1ps
`default_nettype none
module cbaz_loop_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ph1,
    input wire logic ph2,
    input wire logic scheme_b,
    input wire logic signed [2:0] offset,
    input wire logic signed [2:0] vin,
    output logic comp
);
    logic in2_r;
    logic ph1_r;
    logic ph2_r;
    logic [1:0] tick_r;
    logic signed [3:0] dens;
    // ones per four clocks; input off, reversed or straight by phase
    assign dens = 4'sh2 + offset +
        (in2_r ? vin : (scheme_b ? -vin : 4'sh0));
    // balanced input toggles every clock, else a period-4 pattern
    assign comp = (dens == 4'sh2) ? tick_r[0] :
        ($signed({2'b00, tick_r}) < dens);
    // switches move when a phase ends: the pause hides the loop delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {in2_r, ph1_r, ph2_r, tick_r} <= 5'h00;
        end else begin
            tick_r <= tick_r + 2'h1;
            ph1_r <= ph1;
            ph2_r <= ph2;
            if (ph1_r && !ph1) in2_r <= 1'b1;
            if (ph2_r && !ph2) in2_r <= 1'b0;
        end
    end
endmodule : cbaz_loop_model
`default_nettype wire

// >>> bench/cbaz_props.sv
// checker: port-level properties of the auto-zero counter
`timescale 1ns/1ps
`default_nettype none
module cbaz_props #(
    parameter int PHASE_CLKS = 40,
    parameter int SETTLE_CLKS = 8
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic COMP_IN,
    input wire logic MOD_OUT,
    input wire logic SWITCH_POS,
    input wire logic SWITCH_NEG,
    input wire logic FIRST_PHASE_INDICATOR,
    input wire logic SECOND_PHASE_INDICATOR,
    input wire logic [cbaz_pkg::READ_W-1:0] READING,
    input wire logic OVERRANGE_FLAG
);
    int up_r;
    int len1_r;
    int len2_r;
    int gap_r;
    logic seen2_r;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // run lengths; cleared by reset so a mid-run reset starts them afresh
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            up_r <= 0;
            len1_r <= 0;
            len2_r <= 0;
            gap_r <= 0;
            seen2_r <= 1'b0;
        end else begin
            up_r <= (up_r < 8) ? up_r + 1 : up_r;
            len1_r <= FIRST_PHASE_INDICATOR ? len1_r + 1 : 0;
            len2_r <= SECOND_PHASE_INDICATOR ? len2_r + 1 : 0;
            gap_r <= (FIRST_PHASE_INDICATOR | SECOND_PHASE_INDICATOR) ?
                0 : gap_r + 1;
            seen2_r <= seen2_r | SECOND_PHASE_INDICATOR;
        end
    end
    sequence s_ph1_done;
        FIRST_PHASE_INDICATOR ##1 !FIRST_PHASE_INDICATOR;
    endsequence
    // first cycles after reset are skipped: the pipeline still holds zeros
    AST_MOD_DELAY: assert property (
        up_r == 8 |-> MOD_OUT == $past(COMP_IN, 3))
        else $error("modulator output lags comparator wrongly");
    AST_SWITCH: assert property (
        SWITCH_POS == MOD_OUT && SWITCH_NEG == !MOD_OUT)
        else $error("current switches disagree with modulator");
    AST_EXCL: assert property (
        !(FIRST_PHASE_INDICATOR && SECOND_PHASE_INDICATOR))
        else $error("both phases active together");
    AST_PH1_LEN: assert property (
        $fell(FIRST_PHASE_INDICATOR) |-> len1_r == PHASE_CLKS)
        else $error("first phase has wrong length");
    AST_PH2_LEN: assert property (
        $fell(SECOND_PHASE_INDICATOR) |-> len2_r == PHASE_CLKS)
        else $error("second phase has wrong length");
    AST_SETTLE: assert property (
        $rose(SECOND_PHASE_INDICATOR) |-> gap_r == SETTLE_CLKS)
        else $error("pause before second phase has wrong length");
    AST_CYCLE_GAP: assert property (
        $rose(FIRST_PHASE_INDICATOR) && seen2_r |-> gap_r == SETTLE_CLKS)
        else $error("pause before first phase has wrong length");
    AST_ORDER: assert property (
        s_ph1_done |-> !SECOND_PHASE_INDICATOR [*3])
        else $error("second phase follows first without a pause");
    AST_READ_HOLD: assert property (
        $changed(READING) |-> $past(SECOND_PHASE_INDICATOR, 1) ||
            $past(SECOND_PHASE_INDICATOR, 2) ||
            $past(SECOND_PHASE_INDICATOR, 3))
        else $error("reading changed away from cycle start");
    AST_OVR: assert property (
        OVERRANGE_FLAG |-> READING == 12'h7cf)
        else $error("overrange without full-scale reading");
endmodule : cbaz_props
bind cbaz_counter cbaz_props #(
    .PHASE_CLKS(PHASE_CLKS),
    .SETTLE_CLKS(SETTLE_CLKS)
) u_props (
    .SYS_CLK(SYS_CLK),
    .RSTN(RSTN),
    .COMP_IN(COMP_IN),
    .MOD_OUT(MOD_OUT),
    .SWITCH_POS(SWITCH_POS),
    .SWITCH_NEG(SWITCH_NEG),
    .FIRST_PHASE_INDICATOR(FIRST_PHASE_INDICATOR),
    .SECOND_PHASE_INDICATOR(SECOND_PHASE_INDICATOR),
    .READING(READING),
    .OVERRANGE_FLAG(OVERRANGE_FLAG)
);
`default_nettype wire

// >>> rtl/cbaz_counter.sv
// digital side of a charge balancing voltmeter with digital auto-zero
`timescale 1ns/1ps
`default_nettype none
module cbaz_counter #(
    parameter int PHASE_CLKS = cbaz_pkg::PHASE_LEN,
    parameter int SETTLE_CLKS = cbaz_pkg::SETTLE_LEN
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic COMP_IN,
    output logic MOD_OUT,
    output logic SWITCH_POS,
    output logic SWITCH_NEG,
    output logic FIRST_PHASE_INDICATOR,
    output logic SECOND_PHASE_INDICATOR,
    output logic [cbaz_pkg::READ_W-1:0] READING,
    output logic READING_NEG,
    output logic OVERRANGE_FLAG,
    output logic INVALID_FLAG,
    output logic READING_VALID
);
    localparam int AW = cbaz_pkg::ACC_W;
    localparam int TW = cbaz_pkg::TIMER_W;
    localparam logic [TW-1:0] PH_LAST = TW'(PHASE_CLKS - 1);
    localparam logic [TW-1:0] ST_LAST = TW'(SETTLE_CLKS - 1);
    // raw preset is minus phase clocks: guard bits included
    localparam logic signed [AW-1:0] PRESET = -AW'(PHASE_CLKS);
    // overrange sits at 2000 of 5000 display periods per phase; the raw
    // threshold follows PHASE_CLKS so that short phases still reach it,
    // while at the default length it comes to 8000 raw counts
    // (the product stays well inside 32 bits for any sane length)
    localparam logic [AW-1:0] OVR_RAW = AW'(cbaz_pkg::OVERRANGE *
        cbaz_pkg::PRESCALE * PHASE_CLKS / cbaz_pkg::PHASE_LEN);

    // reset and comparator pipeline
    logic rst_meta_r;
    logic rst_n;
    logic comp_s;
    logic mod_r;
    // sequencer
    cbaz_pkg::cbaz_state_type state_r;
    cbaz_pkg::cbaz_state_type state_nxt;
    logic [TW-1:0] timer_r;
    logic [TW-1:0] timer_nxt;
    // accumulator and saturation watch
    logic signed [AW-1:0] acc_r;
    logic signed [AW-1:0] acc_nxt;
    wire logic [1:0] seen_now;
    logic sat_r;
    // display latch; it holds one result for a whole cycle
    // so the outside never sees a half-built count
    logic [cbaz_pkg::READ_W-1:0] reading_r;
    logic neg_r;
    logic ovr_r;
    logic inv_r;
    logic valid_r;
    logic timer_seen_r;

    // true while a counting phase runs; settle windows count nothing,
    // and several watchers below need the same decode
    function automatic logic counting(input cbaz_pkg::cbaz_state_type s);
        counting = (s == cbaz_pkg::ST_PHASE1) || (s == cbaz_pkg::ST_PHASE2);
    endfunction : counting

    // reset release through two flops; assertion stays asynchronous,
    // while release is clean so no flop leaves reset on a different
    // edge from its neighbours
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // comparator comes from the analog side, so synchronise it;
    // the two extra clocks of lag are the same in both phases
    // and so drop out of the net count
    cbaz_sync u_comp_sync (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .d(COMP_IN),
        .q(comp_s)
    );

    // modulator flip-flop samples comparator every clock;
    // MOD_OUT thus trails COMP_IN by three clocks in all
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mod_r <= 1'b0;
        end else begin
            mod_r <= comp_s;
        end
    end

    // true and inverted outputs steer opposing reference switches;
    // the analog loop makes a balanced input alternate them
    assign MOD_OUT = mod_r;
    assign SWITCH_POS = mod_r;
    assign SWITCH_NEG = ~mod_r;

    // phase sequencer: settle, phase 1, settle, phase 2 = 48000 clocks;
    // the cycle length never depends on the input, so a reading always
    // arrives at the same rate
    wire phase_end = (timer_r == PH_LAST);
    wire settle_end = (timer_r == ST_LAST);
    wire in_p1 = (state_r == cbaz_pkg::ST_PHASE1);
    wire in_p2 = (state_r == cbaz_pkg::ST_PHASE2);
    wire cycle_start = (state_r == cbaz_pkg::ST_SETTLE1) && (timer_r == '0);

    // each window runs its length, then the timer restarts at zero
    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r + TW'(1);
        case (state_r)
            cbaz_pkg::ST_SETTLE1: begin
                if (settle_end) begin
                    state_nxt = cbaz_pkg::ST_PHASE1;
                    timer_nxt = '0;
                end
            end
            cbaz_pkg::ST_PHASE1: begin
                if (phase_end) begin
                    state_nxt = cbaz_pkg::ST_SETTLE2;
                    timer_nxt = '0;
                end
            end
            cbaz_pkg::ST_SETTLE2: begin
                if (settle_end) begin
                    state_nxt = cbaz_pkg::ST_PHASE2;
                    timer_nxt = '0;
                end
            end
            cbaz_pkg::ST_PHASE2: begin
                if (phase_end) begin
                    state_nxt = cbaz_pkg::ST_SETTLE1;
                    timer_nxt = '0;
                end
            end
            default: begin
                state_nxt = cbaz_pkg::ST_SETTLE1;
                timer_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= cbaz_pkg::ST_SETTLE1;
            timer_r <= '0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // indicators let the external switches follow the phases;
    // which scheme (disconnect or reverse) is up to the outside
    assign FIRST_PHASE_INDICATOR = in_p1;
    assign SECOND_PHASE_INDICATOR = in_p2;

    // accumulator: the two low bits are the divide-by-four guard bits,
    // so 20000 clocks count as 5000 display periods per phase;
    // phase one adds the inverted output on top of minus the phase
    // length, phase two adds the true output, so any offset common to
    // both phases cancels and only the input difference remains
    wire count_p1 = in_p1 && !mod_r;
    wire count_p2 = in_p2 && mod_r;
    always_comb begin
        acc_nxt = acc_r;
        if (cycle_start) begin
            acc_nxt = PRESET;
        end else if (count_p1 || count_p2) begin
            acc_nxt = acc_r + AW'(1);
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // saturation watch: each level flag records whether the modulator
    // showed that level at least once in the running phase; a phase
    // that lacks either level means the loop sat against a rail
    wire in_meas = counting(state_r);
    wire ph_first = in_meas && (timer_r == '0);
    wire phase_last = in_meas && phase_end;
    // index 0 watches low samples, index 1 watches high samples
    genvar lvl;
    generate
        for (lvl = 0; lvl < 2; lvl++) begin : g_seen
            logic seen_r;
            // this sample shows the watched level
            wire hit = in_meas && (mod_r == 1'(lvl));
            // the first clock of a phase restarts the flag
            always_ff @(posedge SYS_CLK or negedge rst_n) begin
                if (!rst_n) begin
                    seen_r <= 1'b0;
                end else if (ph_first) begin
                    seen_r <= hit;
                end else begin
                    seen_r <= seen_r | hit;
                end
            end
            // the last sample of a phase has not reached the flag yet
            assign seen_now[lvl] = seen_r | hit;
        end
    endgenerate

    // rail detect sticks until the next cycle start clears it
    wire pinned = ~&seen_now;
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sat_r <= 1'b0;
        end else if (cycle_start) begin
            sat_r <= 1'b0;
        end else if (phase_last && pinned) begin
            sat_r <= 1'b1;
        end
    end

    // display conversion: magnitude with round-half-up on guard bits;
    // the sign comes from the rounded value so zero never shows minus
    wire acc_neg = acc_r[AW-1];
    wire [AW-1:0] acc_mag = acc_neg ? AW'(-acc_r) : AW'(acc_r);
    wire [AW-1:0] rounded = (acc_mag + AW'(2)) >> cbaz_pkg::GUARD_BITS;
    wire show_neg = acc_neg && (rounded != '0);
    wire over = (acc_mag >= OVR_RAW);
    // full scale of either switching scheme comes from analog scaling:
    // 4500 or 3500 pulses per phase land on the same raw count
    wire [cbaz_pkg::READ_W-1:0] read_val =
        over ? cbaz_pkg::READ_W'(cbaz_pkg::OVERRANGE - 1)
             : cbaz_pkg::READ_W'(rounded);

    // transfer the finished count to the display at cycle start;
    // the accumulator is preset on that same edge, so the latch takes
    // the old value just before it is lost
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            reading_r <= '0;
            neg_r <= 1'b0;
            ovr_r <= 1'b0;
            inv_r <= 1'b0;
            valid_r <= 1'b0;
        end else if (cycle_start && timer_seen_r) begin
            reading_r <= read_val;
            neg_r <= show_neg;
            ovr_r <= over;
            inv_r <= sat_r;
            valid_r <= 1'b1;
        end
    end

    // first cycle after reset has no previous count to show;
    // a mid-run reset clears this again, so a cut cycle never
    // reaches the display
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            timer_seen_r <= 1'b0;
        end else if (in_p2 && phase_end) begin
            timer_seen_r <= 1'b1;
        end
    end

    // result outputs come straight from flip-flops
    assign READING = reading_r;
    assign READING_NEG = neg_r;
    assign OVERRANGE_FLAG = ovr_r;
    assign INVALID_FLAG = inv_r;
    assign READING_VALID = valid_r;
endmodule : cbaz_counter
`default_nettype wire

// >>> rtl/cbaz_pkg.sv
// package: constants for the charge balance auto-zero counter
package cbaz_pkg;
    // whole cycle: settle + phase1 + settle + phase2
    localparam int CYCLE_LEN = 48000;
    localparam int PHASE_LEN = 20000;
    localparam int SETTLE_LEN = 4000;
    localparam int TIMER_W = 16;
    // modulator clocks per phase as seen after the divide-by-four stage
    localparam int PHASE_COUNTS = 5000;
    localparam int PRESCALE = 4;
    localparam int GUARD_BITS = 2;
    // zero-input count per phase and full-scale references
    localparam int ZERO_COUNT = 2500;
    localparam int FS_SCHEME_A = 4500;
    localparam int FS_SCHEME_B = 3500;
    localparam int OVERRANGE = 2000;
    // accumulator width: holds -20000..+20000 raw (with guard bits)
    localparam int ACC_W = 17;
    localparam int READ_W = 12;

    typedef enum logic [3:0] {
        ST_SETTLE1 = 4'b0001,
        ST_PHASE1 = 4'b0010,
        ST_SETTLE2 = 4'b0100,
        ST_PHASE2 = 4'b1000
    } cbaz_state_type;
endpackage : cbaz_pkg

// >>> rtl/cbaz_sync.sv
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module cbaz_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : cbaz_sync
`default_nettype wire
